// [rtl/efsc_regs.vh]
/*
  register offsets, status field positions and timing constants of the
  energy freeze, status and checksum block.
  assumes it is included by bare name from the design file.
*/
`ifndef EFSC_REGS_VH
`define EFSC_REGS_VH

// register offsets on the host register port
`define EFSC_ADDR_ENERGY_ACT 7'h29
`define EFSC_ADDR_ENERGY_ACT2 7'h2a
`define EFSC_ADDR_ENERGY_RC 7'h2b
`define EFSC_ADDR_ENERGY_RC2 7'h2c
`define EFSC_ADDR_STATUS 7'h2d

// calibration range covered by the checksum
`define EFSC_CAL_FIRST 5'h00
`define EFSC_CAL_LAST 5'h17
`define EFSC_CAL_LAST_ADDR 7'h17
// single-byte phase calibration registers inside that range
`define EFSC_ADDR_PHASE_CAL_A 5'h0d
`define EFSC_ADDR_PHASE_CAL_B 5'h0e

// status register field positions
`define EFSC_ST_REF_LOW 22
`define EFSC_ST_CHAN_B 21
`define EFSC_ST_NO_CUSTOM 20
`define EFSC_ST_NO_ACTIVE 19
`define EFSC_ST_REV_CUSTOM 18
`define EFSC_ST_REV_ACTIVE 17
`define EFSC_ST_CHK_BUSY 16

// energy register and checksum word values
`define EFSC_ENERGY_ZERO 24'h00_0000
`define EFSC_ENERGY_ONE 24'h00_0001
`define EFSC_ENERGY_FULL 24'hff_ffff
`define EFSC_WORD_ZERO 16'h0000
`define EFSC_BYTE_MASK 16'h00ff
`define EFSC_WORD_MASK 16'hffff

// checksum duration: time in ns, clock period in ns, cycles rounded up
`define EFSC_CHK_TIME_NS 11200
`define EFSC_CLK_PERIOD_NS 10
`define EFSC_CHK_CYCLES ((`EFSC_CHK_TIME_NS + `EFSC_CLK_PERIOD_NS - 1) / `EFSC_CLK_PERIOD_NS)

`endif

// [rtl/efsc_top.v]
/*
  energy freeze, status and checksum register logic of a metering front end:
  second active energy, reactive or custom energy and its second copy,
  primary active energy, the metering status word and the calibration
  checksum engine.
  assumes a host framing block delivers one-cycle read and write strobes
  with an address, that calibration storage answers cal_rd_addr_out in the
  same cycle, and that pulse and sign inputs come from the metering core.
*/
// Behaviour
// - unfrozen second active energy counts, clears on read
// - frozen: copy active energy, clear primary periodically
// - accumulate mode flags reactive wrap to zero
// - control bit 15 set: reactive clears on read
// - reactive energy counts reactive output pulses
// - reactive or custom source chosen by control two
// - unfrozen second reactive counts, clears on read
// - frozen: copy reactive energy, clear primary periodically
// - status bit 22 shows reference voltage low
// - status bit 21 shows channel B, resets A
// - status bit 20 custom power below start
// - status bit 19 active power below start
// - bit 18 custom sign, updates on reactive pulse
// - bit 17 active sign, updates on active pulse
// - bit 16 busy while checksum computes
// - low sixteen bits checksum, bit 23 zero, read-only
// - checksum is inverted sum of sixteen-bit words
// - phase byte registers enter with zero upper byte
// - checksum covers calibration addresses zero to seventeen hex
// - spi mode with defaults gives documented value
// - uart mode adds read-only upper bits too
// - restart on reset, range write, status read
`timescale 1ns/10ps
`include "efsc_regs.vh"

module efsc_top #(
  parameter CLK_HZ = 100000000,   // system clock rate
  parameter XTAL_HZ = 3579545,    // crystal rate that paces the freeze
  parameter FREEZE_W = 21,        // freeze counter width
  parameter FREEZE_CYCLES = 2097152, // crystal cycles per freeze period
  parameter CHK_CYCLES = `EFSC_CHK_CYCLES // system cycles per checksum
) (
  // clock and reset
  input wire clk_in,
  input wire rst_n_in,
  // host register port
  input wire rd_strobe_in,
  input wire wr_strobe_in,
  input wire [6:0] addr_in,
  output wire [23:0] rd_data_out,
  // control bits
  input wire freeze_select_in,
  input wire metering_control_clr_in,
  input wire metering_control_two_custom_in,
  input wire uart_mode_in,
  // metering core events and levels
  input wire active_pulse_out_in,
  input wire reactive_pulse_out_in,
  input wire active_neg_in,
  input wire custom_neg_in,
  input wire active_below_start_in,
  input wire custom_below_start_in,
  input wire reference_low_flag_in,
  input wire current_channel_indicator_in,
  // calibration storage read port
  output wire [4:0] cal_rd_addr_out,
  input wire [15:0] cal_rd_data_in,
  input wire [15:0] cal_rd_hi_in,
  // events to interrupt flags and source select
  output wire active_overflow_out,
  output wire reactive_overflow_flag_out,
  output wire freeze_event_out,
  output wire custom_source_out
);

  // checksum engine states
  localparam ST_IDLE = 3'b001;
  localparam ST_SUM = 3'b010;
  localparam ST_WAIT = 3'b100;
  localparam CHK_W = 11;           // width of checksum cycle counter
  localparam ACC_W = 28;           // crystal phase accumulator width

  // crystal enable divider
  reg [ACC_W-1:0] xtal_acc_r;      // fractional phase
  reg xtal_tick_r;                 // one-cycle crystal enable
  wire [ACC_W-1:0] xtal_sum;       // phase plus crystal step
  // freeze timing
  reg [FREEZE_W-1:0] freeze_cnt_r; // free-running crystal count
  reg freeze_evt_r;                // registered freeze pulse
  wire freeze_tc;                  // terminal count this cycle
  wire freeze_now;                 // copy and clear this cycle
  // energy registers
  reg [23:0] energy_act_r;         // primary active energy
  reg [23:0] energy_act2_r;        // second active energy
  reg [23:0] energy_rc_r;          // reactive or custom energy
  reg [23:0] energy_rc2_r;         // second reactive or custom energy
  reg act_ovf_r;                   // active wrap pulse
  reg rc_ovf_r;                    // reactive wrap pulse
  // status bits
  reg rev_act_r;                   // active sign latch
  reg rev_custom_r;                // custom sign latch
  reg chk_busy_r;                  // checksum in progress
  reg [15:0] chk_val_r;            // last valid checksum
  // checksum engine
  reg [2:0] chk_state_r;
  reg [2:0] chk_state_nxt;
  reg [4:0] chk_idx_r;             // calibration word being summed
  reg [CHK_W-1:0] chk_cyc_r;       // cycles since start
  reg [15:0] chk_sum_r;            // running word sum
  reg [15:0] chk_word;             // word entering the sum this cycle
  wire chk_restart;                // start a fresh computation
  wire chk_last_cyc;               // computation time elapsed
  // host access decode
  reg [23:0] rd_data_r;            // captured read data
  wire rd_act;
  wire rd_act2;
  wire rd_rc;
  wire rd_rc2;
  wire rd_status;
  wire wr_cal;
  wire [23:0] status_word;

  // address match used by every read decode
  function hit;
    input [6:0] a;
    input [6:0] b;
    begin
      hit = (a == b);
    end
  endfunction

  // single-byte phase registers keep only their low byte
  function is_byte_reg;
    input [4:0] a;
    begin
      is_byte_reg = (a == `EFSC_ADDR_PHASE_CAL_A) || (a == `EFSC_ADDR_PHASE_CAL_B);
    end
  endfunction

  assign rd_act = rd_strobe_in & hit(addr_in, `EFSC_ADDR_ENERGY_ACT);
  assign rd_act2 = rd_strobe_in & hit(addr_in, `EFSC_ADDR_ENERGY_ACT2);
  assign rd_rc = rd_strobe_in & hit(addr_in, `EFSC_ADDR_ENERGY_RC);
  assign rd_rc2 = rd_strobe_in & hit(addr_in, `EFSC_ADDR_ENERGY_RC2);
  assign rd_status = rd_strobe_in & hit(addr_in, `EFSC_ADDR_STATUS);
  // writes only matter for the covered calibration range
  assign wr_cal = wr_strobe_in & (addr_in <= `EFSC_CAL_LAST_ADDR);

  // crystal enable from a fractional accumulator
  assign xtal_sum = xtal_acc_r + XTAL_HZ[ACC_W-1:0];
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      xtal_acc_r <= {ACC_W{1'b0}};
      xtal_tick_r <= 1'b0;
    end else if (xtal_sum >= CLK_HZ[ACC_W-1:0]) begin
      xtal_acc_r <= xtal_sum - CLK_HZ[ACC_W-1:0];
      xtal_tick_r <= 1'b1;
    end else begin
      xtal_acc_r <= xtal_sum;
      xtal_tick_r <= 1'b0;
    end
  end

  // free-running freeze period counter on crystal ticks
  assign freeze_tc = xtal_tick_r && (freeze_cnt_r == FREEZE_CYCLES[FREEZE_W-1:0] - 1'b1);
  assign freeze_now = freeze_tc & freeze_select_in;
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      freeze_cnt_r <= {FREEZE_W{1'b0}};
      freeze_evt_r <= 1'b0;
    end else begin
      freeze_evt_r <= freeze_now;
      if (freeze_tc) begin
        freeze_cnt_r <= {FREEZE_W{1'b0}};
      end else if (xtal_tick_r) begin
        freeze_cnt_r <= freeze_cnt_r + 1'b1;
      end
    end
  end

  // primary active energy: counts pulses, cleared on freeze or on read clear
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      energy_act_r <= `EFSC_ENERGY_ZERO;
      act_ovf_r <= 1'b0;
    end else begin
      act_ovf_r <= active_pulse_out_in & ~metering_control_clr_in &
                   (energy_act_r == `EFSC_ENERGY_FULL);
      if (freeze_now) begin
        // a pulse in the freeze cycle starts the next period
        energy_act_r <= active_pulse_out_in ? `EFSC_ENERGY_ONE : `EFSC_ENERGY_ZERO;
      end else if (rd_act && metering_control_clr_in) begin
        energy_act_r <= active_pulse_out_in ? `EFSC_ENERGY_ONE : `EFSC_ENERGY_ZERO;
      end else if (active_pulse_out_in) begin
        energy_act_r <= energy_act_r + `EFSC_ENERGY_ONE;
      end
    end
  end

  // second active energy: own counter or frozen copy
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      energy_act2_r <= `EFSC_ENERGY_ZERO;
    end else if (freeze_select_in) begin
      if (freeze_now) begin
        energy_act2_r <= energy_act_r;
      end
    end else if (rd_act2) begin
      // a pulse in the read cycle is kept
      energy_act2_r <= active_pulse_out_in ? `EFSC_ENERGY_ONE : `EFSC_ENERGY_ZERO;
    end else if (active_pulse_out_in) begin
      energy_act2_r <= energy_act2_r + `EFSC_ENERGY_ONE;
    end
  end

  // reactive or custom energy: counts reactive pulses
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      energy_rc_r <= `EFSC_ENERGY_ZERO;
      rc_ovf_r <= 1'b0;
    end else begin
      // wrap flag only in accumulate mode
      rc_ovf_r <= reactive_pulse_out_in & ~metering_control_clr_in &
                  (energy_rc_r == `EFSC_ENERGY_FULL);
      if (freeze_now) begin
        energy_rc_r <= reactive_pulse_out_in ? `EFSC_ENERGY_ONE : `EFSC_ENERGY_ZERO;
      end else if (rd_rc && metering_control_clr_in) begin
        energy_rc_r <= reactive_pulse_out_in ? `EFSC_ENERGY_ONE : `EFSC_ENERGY_ZERO;
      end else if (reactive_pulse_out_in) begin
        energy_rc_r <= energy_rc_r + `EFSC_ENERGY_ONE;
      end
    end
  end

  // second reactive or custom energy: own counter or frozen copy
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      energy_rc2_r <= `EFSC_ENERGY_ZERO;
    end else if (freeze_select_in) begin
      if (freeze_now) begin
        energy_rc2_r <= energy_rc_r;
      end
    end else if (rd_rc2) begin
      energy_rc2_r <= reactive_pulse_out_in ? `EFSC_ENERGY_ONE : `EFSC_ENERGY_ZERO;
    end else if (reactive_pulse_out_in) begin
      energy_rc2_r <= energy_rc2_r + `EFSC_ENERGY_ONE;
    end
  end

  // sign latches refresh only when the matching pulse goes out
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      rev_act_r <= 1'b0;
      rev_custom_r <= 1'b0;
    end else begin
      if (active_pulse_out_in) begin
        rev_act_r <= active_neg_in;
      end
      if (reactive_pulse_out_in) begin
        rev_custom_r <= custom_neg_in;
      end
    end
  end

  // checksum engine control
  assign chk_restart = wr_cal | rd_status;
  assign chk_last_cyc = (chk_cyc_r == CHK_CYCLES[CHK_W-1:0] - 1'b1);
  assign cal_rd_addr_out = chk_idx_r;

  // word entering the sum: byte registers zero extended, uart adds upper bits
  always @* begin
    chk_word = cal_rd_data_in;
    if (is_byte_reg(chk_idx_r)) begin
      chk_word = cal_rd_data_in & `EFSC_BYTE_MASK;
    end
    if (uart_mode_in) begin
      chk_word = chk_word + cal_rd_hi_in;
    end
  end

  // next state of the checksum engine
  always @* begin
    chk_state_nxt = chk_state_r;
    case (chk_state_r)
      ST_IDLE: begin
        chk_state_nxt = ST_IDLE;
      end
      ST_SUM: begin
        // last covered word moves to the wait for the full duration
        if (chk_idx_r == `EFSC_CAL_LAST) begin
          chk_state_nxt = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (chk_last_cyc) begin
          chk_state_nxt = ST_IDLE;
        end
      end
      default: begin
        chk_state_nxt = ST_IDLE;
      end
    endcase
    if (chk_restart) begin
      chk_state_nxt = ST_SUM;
    end
  end

  // checksum datapath and busy flag
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      // reset itself starts a computation
      chk_state_r <= ST_SUM;
      chk_idx_r <= `EFSC_CAL_FIRST;
      chk_cyc_r <= {CHK_W{1'b0}};
      chk_sum_r <= `EFSC_WORD_ZERO;
      chk_busy_r <= 1'b1;
      chk_val_r <= `EFSC_WORD_ZERO;
    end else begin
      chk_state_r <= chk_state_nxt;
      if (chk_restart) begin
        chk_idx_r <= `EFSC_CAL_FIRST;
        chk_cyc_r <= {CHK_W{1'b0}};
        chk_sum_r <= `EFSC_WORD_ZERO;
        chk_busy_r <= 1'b1;
      end else begin
        if (chk_state_r != ST_IDLE) begin
          chk_cyc_r <= chk_cyc_r + 1'b1;
        end
        if (chk_state_r == ST_SUM) begin
          chk_sum_r <= chk_sum_r + chk_word;
          chk_idx_r <= (chk_idx_r == `EFSC_CAL_LAST) ? chk_idx_r : chk_idx_r + 1'b1;
        end
        if ((chk_state_r == ST_WAIT) && chk_last_cyc) begin
          chk_val_r <= chk_sum_r ^ `EFSC_WORD_MASK;
          chk_busy_r <= 1'b0;
        end
      end
    end
  end

  // status word, bit 23 fixed at zero
  assign status_word = {1'b0,
                        reference_low_flag_in,
                        current_channel_indicator_in,
                        custom_below_start_in,
                        active_below_start_in,
                        rev_custom_r,
                        rev_act_r,
                        chk_busy_r,
                        chk_val_r};

  // read capture; values are those before any read side effect
  always @(posedge clk_in) begin
    if (!rst_n_in) begin
      rd_data_r <= `EFSC_ENERGY_ZERO;
    end else if (rd_strobe_in) begin
      if (rd_act) begin
        rd_data_r <= energy_act_r;
      end else if (rd_act2) begin
        rd_data_r <= energy_act2_r;
      end else if (rd_rc) begin
        rd_data_r <= energy_rc_r;
      end else if (rd_rc2) begin
        rd_data_r <= energy_rc2_r;
      end else if (rd_status) begin
        rd_data_r <= status_word;
      end else begin
        // other addresses belong to other blocks
        rd_data_r <= `EFSC_ENERGY_ZERO;
      end
    end
  end

  // outputs
  assign rd_data_out = rd_data_r;
  assign active_overflow_out = act_ovf_r;
  assign reactive_overflow_flag_out = rc_ovf_r;
  assign freeze_event_out = freeze_evt_r;
  // source selection passes to the metering core feeding the reactive pulses
  assign custom_source_out = metering_control_two_custom_in;

endmodule // efsc_top

// [verif/efsc_cal_model.sv]
/*
  calibration storage model: 32 words answered in the same cycle,
  plus a read-only upper word per index; the bench may rewrite mem.
*/
`timescale 1ns/10ps
module efsc_cal_model (
  // read port from the checksum engine
  input wire [4:0] idx_in,
  output wire [15:0] word_out,
  output wire [15:0] hi_out
);
  reg [15:0] mem [0:31]; // calibration words
  integer i; // fill index
  // power-up contents, a distinct value per word
  initial begin
    for (i = 0; i < 32; i = i + 1) begin
      mem[i] = 16'h0301 * i[15:0] + 16'h0a05;
    end
  end
  // storage answers combinationally
  assign word_out = mem[idx_in];
  // read-only upper bits, small per-index value
  assign hi_out = {11'h000, idx_in};
endmodule // efsc_cal_model

// [verif/efsc_chk_props.sv]
/*
  checker: concurrent properties on the ports of efsc_top, bound below.
  assumes one clock and a synchronous active-low reset.
*/
`timescale 1ns/10ps
`include "efsc_regs.vh"
module efsc_chk #(
  parameter CHK_CYCLES = 1120 // checksum span, handed on from the design
) (
  // clock and reset
  input wire clk_in,
  input wire rst_n_in,
  // host register port
  input wire rd_strobe_in,
  input wire wr_strobe_in,
  input wire [6:0] addr_in,
  input wire [23:0] rd_data_out,
  // control and status levels
  input wire freeze_select_in,
  input wire metering_control_clr_in,
  input wire metering_control_two_custom_in,
  input wire active_below_start_in,
  input wire custom_below_start_in,
  input wire reference_low_flag_in,
  input wire current_channel_indicator_in,
  // calibration port and events
  input wire [4:0] cal_rd_addr_out,
  input wire reactive_overflow_flag_out,
  input wire freeze_event_out,
  input wire custom_source_out
);
  wire st_rd; // status read taken
  wire restart; // checksum restart request
  assign st_rd = rd_strobe_in && (addr_in == `EFSC_ADDR_STATUS);
  assign restart = st_rd || (wr_strobe_in && (addr_in <= `EFSC_CAL_LAST_ADDR));
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  a_status_top_zero: assert property (st_rd |=> rd_data_out[23] == 1'b0)
    else $error("status top bit not zero");
  a_ref_low_shown: assert property (st_rd |=> rd_data_out[22] == $past(reference_low_flag_in))
    else $error("reference low bit wrong");
  a_chan_sel_shown: assert property (st_rd |=> rd_data_out[21] == $past(current_channel_indicator_in))
    else $error("channel bit wrong");
  a_below_start_shown: assert property (st_rd |=>
    rd_data_out[20:19] == $past({custom_below_start_in, active_below_start_in}))
    else $error("below start bits wrong");
  a_busy_after_restart: assert property (st_rd ##[1:8] st_rd |=> rd_data_out[16])
    else $error("busy not shown after status read");
  a_sum_walk_start: assert property (restart ##1 !restart |->
    cal_rd_addr_out == 5'h00 ##1 cal_rd_addr_out == 5'h01)
    else $error("checksum walk did not restart");
  a_cal_index_range: assert property (cal_rd_addr_out <= `EFSC_CAL_LAST)
    else $error("calibration index out of range");
  a_freeze_mode_gap: assert property (freeze_event_out |->
    $past(freeze_select_in) ##1 !freeze_event_out [*8])
    else $error("freeze event without freeze mode");
  a_ovf_accum_only: assert property (reactive_overflow_flag_out |-> !$past(metering_control_clr_in))
    else $error("overflow in clear mode");
  a_source_follows: assert property (custom_source_out == metering_control_two_custom_in)
    else $error("source select not passed");
  c_status_read: cover property (st_rd);
  c_freeze: cover property (freeze_event_out);
  c_restart: cover property (restart ##1 !restart);
endmodule // efsc_chk

bind efsc_top efsc_chk #(.CHK_CYCLES(CHK_CYCLES)) i_chk (.clk_in, .rst_n_in, .rd_strobe_in,
  .wr_strobe_in, .addr_in, .rd_data_out, .freeze_select_in, .metering_control_clr_in,
  .metering_control_two_custom_in, .active_below_start_in, .custom_below_start_in,
  .reference_low_flag_in, .current_channel_indicator_in, .cal_rd_addr_out,
  .reactive_overflow_flag_out, .freeze_event_out, .custom_source_out);

// [verif/efsc_top_test.sv]
/*
  testbench of efsc_top: register reads and writes, pulses, freeze.
  assumes the calibration model answers cal_rd_addr_out in the same cycle.
*/
`timescale 1ns/10ps
`include "efsc_regs.vh"
module efsc_top_test;
  localparam CHK = 40; // shortened checksum span
  reg clk_in;
  reg rst_n_in = 1'b0, rd_strobe_in = 1'b0, wr_strobe_in = 1'b0, freeze_select_in = 1'b0;
  reg metering_control_clr_in = 1'b0, metering_control_two_custom_in = 1'b1, uart_mode_in = 1'b0;
  reg active_pulse_out_in = 1'b0, reactive_pulse_out_in = 1'b0;
  reg active_neg_in = 1'b0, custom_neg_in = 1'b0, active_below_start_in = 1'b1;
  reg custom_below_start_in = 1'b0, reference_low_flag_in = 1'b1, current_channel_indicator_in = 1'b0;
  reg [6:0] addr_in = 7'h00;
  wire [23:0] rd_data_out;
  wire [4:0] cal_rd_addr_out;
  wire [15:0] cal_w, cal_h;
  wire reactive_overflow_flag_out, freeze_event_out, custom_source_out;
  reg [15:0] tbm [0:23]; // expected calibration contents
  reg [23:0] d; // scratch read data
  integer errors = 0, checks = 0, k;
  efsc_top #(.XTAL_HZ(100000000), .FREEZE_CYCLES(64), .CHK_CYCLES(CHK)) i_dut (.clk_in, .rst_n_in,
    .rd_strobe_in, .wr_strobe_in, .addr_in, .rd_data_out, .freeze_select_in,
    .metering_control_clr_in, .metering_control_two_custom_in, .uart_mode_in,
    .active_pulse_out_in, .reactive_pulse_out_in, .active_neg_in, .custom_neg_in,
    .active_below_start_in, .custom_below_start_in, .reference_low_flag_in,
    .current_channel_indicator_in, .cal_rd_addr_out, .cal_rd_data_in(cal_w), .cal_rd_hi_in(cal_h),
    .active_overflow_out(), .reactive_overflow_flag_out, .freeze_event_out, .custom_source_out);
  efsc_cal_model i_cal (.idx_in(cal_rd_addr_out), .word_out(cal_w), .hi_out(cal_h));
  // free-running clock
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  // compare and count
  task chk(input [23:0] seen, input [23:0] exp);
    begin
      checks = checks + 1;
      if (seen !== exp) begin
        errors = errors + 1;
        $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  // one read, data taken the cycle after the strobe
  task rd(input [6:0] a);
    begin
      @(posedge clk_in);
      rd_strobe_in <= 1'b1;
      addr_in <= a;
      @(posedge clk_in);
      rd_strobe_in <= 1'b0;
      // data stands until the next read, so take it one edge later
      @(posedge clk_in);
      d = rd_data_out;
    end
  endtask
  // read and compare under a mask
  task rc(input [6:0] a, input [23:0] e, input [23:0] m);
    begin
      rd(a);
      chk(d & m, e);
    end
  endtask
  // one write strobe
  task wr(input [6:0] a);
    begin
      @(posedge clk_in);
      wr_strobe_in <= 1'b1;
      addr_in <= a;
      @(posedge clk_in);
      wr_strobe_in <= 1'b0;
    end
  endtask
  // n output pulses, two cycles apart
  task pls(input a, input r, input integer n);
    repeat (n) begin
      @(posedge clk_in);
      active_pulse_out_in <= a;
      reactive_pulse_out_in <= r;
      @(posedge clk_in);
      active_pulse_out_in <= 1'b0;
      reactive_pulse_out_in <= 1'b0;
    end
  endtask
  // bounded wait for a freeze event
  task wev;
    integer n;
    begin
      n = 0;
      @(posedge clk_in);
      #1;
      while (freeze_event_out !== 1'b1 && n < 200) begin
        @(posedge clk_in);
        #1;
        n = n + 1;
      end
      chk({23'h00_0000, freeze_event_out}, 24'h00_0001);
    end
  endtask
  // expected checksum from the mirror contents
  function [15:0] cks(input u);
    integer i;
    reg [15:0] s;
    begin
      s = 16'h0000;
      for (i = 0; i < 24; i = i + 1) begin
        s = s + ((i == 13 || i == 14) ? (tbm[i] & 16'h00ff) : tbm[i]);
        if (u) s = s + i[15:0];
      end
      cks = ~s;
    end
  endfunction
  // counts, then verdict
  task stop_test;
    begin
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0) begin
        $display("DONE - PASS");
      end else begin
        $display("DONE - FAIL");
      end
      $finish;
    end
  endtask
  // hang guard
  initial begin
    #200000;
    errors = errors + 1;
    stop_test;
  end
  // main sequence
  initial begin
    for (k = 0; k < 24; k = k + 1) tbm[k] = 16'h0301 * k[15:0] + 16'h0a05;
    repeat (16) @(posedge clk_in);
    rst_n_in <= 1'b1;
    rc(`EFSC_ADDR_STATUS, 24'h49_0000, 24'hf9_0000);
    reference_low_flag_in <= 1'b0;
    current_channel_indicator_in <= 1'b1;
    active_below_start_in <= 1'b0;
    custom_below_start_in <= 1'b1;
    repeat (CHK + 4) @(posedge clk_in);
    rc(`EFSC_ADDR_STATUS, {8'h30, cks(0)}, 24'hf9_ffff);
    rc(`EFSC_ADDR_STATUS, 24'h01_0000, 24'h01_0000);
    $display("test 1 done");
    tbm[13] = 16'hab12;
    i_cal.mem[13] <= 16'hab12;
    wr(7'h0d);
    repeat (CHK + 4) @(posedge clk_in);
    rc(`EFSC_ADDR_STATUS, {8'h00, cks(0)}, 24'h01_ffff);
    repeat (CHK + 4) @(posedge clk_in);
    i_cal.mem[16] <= 16'h5a5a;
    wr(7'h18);
    rc(`EFSC_ADDR_STATUS, {8'h00, cks(0)}, 24'h01_ffff);
    tbm[16] = 16'h5a5a;
    repeat (CHK + 4) @(posedge clk_in);
    rc(`EFSC_ADDR_STATUS, {8'h00, cks(0)}, 24'h01_ffff);
    uart_mode_in <= 1'b1;
    wr(7'h17);
    repeat (CHK + 4) @(posedge clk_in);
    wr(`EFSC_ADDR_STATUS);
    rc(`EFSC_ADDR_STATUS, {8'h00, cks(1)}, 24'h81_ffff);
    rc(7'h30, 24'h00_0000, 24'hff_ffff);
    $display("test 2 done");
    metering_control_clr_in <= 1'b1;
    for (k = 41; k < 45; k = k + 1) rd(k[6:0]);
    active_neg_in <= 1'b1;
    pls(1'b1, 1'b0, 3);
    pls(1'b0, 1'b1, 5);
    rc(`EFSC_ADDR_ENERGY_ACT2, 24'h00_0003, 24'hff_ffff);
    rc(`EFSC_ADDR_ENERGY_ACT2, 24'h00_0000, 24'hff_ffff);
    rc(`EFSC_ADDR_ENERGY_RC2, 24'h00_0005, 24'hff_ffff);
    rc(`EFSC_ADDR_ENERGY_RC2, 24'h00_0000, 24'hff_ffff);
    rc(`EFSC_ADDR_ENERGY_RC, 24'h00_0005, 24'hff_ffff);
    rc(`EFSC_ADDR_ENERGY_RC, 24'h00_0000, 24'hff_ffff);
    metering_control_clr_in <= 1'b0;
    custom_neg_in <= 1'b1;
    pls(1'b0, 1'b1, 2);
    rc(`EFSC_ADDR_ENERGY_RC, 24'h00_0002, 24'hff_ffff);
    rc(`EFSC_ADDR_ENERGY_RC, 24'h00_0002, 24'hff_ffff);
    rc(`EFSC_ADDR_STATUS, 24'h06_0000, 24'h06_0000);
    custom_neg_in <= 1'b0;
    rc(`EFSC_ADDR_STATUS, 24'h06_0000, 24'h06_0000);
    metering_control_two_custom_in <= 1'b0;
    $display("test 3 done");
    freeze_select_in <= 1'b1;
    wev;
    pls(1'b1, 1'b1, 3);
    wev;
    rc(`EFSC_ADDR_ENERGY_ACT2, 24'h00_0003, 24'hff_ffff);
    rc(`EFSC_ADDR_ENERGY_RC2, 24'h00_0003, 24'hff_ffff);
    rc(`EFSC_ADDR_ENERGY_ACT, 24'h00_0000, 24'hff_ffff);
    rc(`EFSC_ADDR_ENERGY_RC, 24'h00_0000, 24'hff_ffff);
    $display("test 4 done");
    stop_test;
  end
endmodule // efsc_top_test
